// ---- logic/ttc_consts.svh ----
// Register offsets, field positions and reset values of the second timer
`ifndef TTC_CONSTS_SVH
`define TTC_CONSTS_SVH
`define TTC_ADDR_CONTROL 8'hC8
`define TTC_ADDR_RELOAD_LO 8'hCA
`define TTC_ADDR_RELOAD_HI 8'hCB
`define TTC_ADDR_COUNT_LO 8'hCC
`define TTC_ADDR_COUNT_HI 8'hCD
`define TTC_ADDR_MODE 8'hC9
`define TTC_ADDR_IRQ_STATUS 8'hE0
`define TTC_ADDR_IRQ_MASK 8'hE1
`define TTC_BIT_OVF 7
`define TTC_BIT_EXF 6
`define TTC_BIT_RCLK 5
`define TTC_BIT_TX_CLOCK_SELECT 4
`define TTC_BIT_EXEN 3
`define TTC_BIT_RUN 2
`define TTC_BIT_CT 1
`define TTC_BIT_CPRL 0
`define TTC_BIT_UP_DOWN_COUNT_ENABLE 0
`define TTC_CONTROL_RESET 8'h00
`define TTC_MASK_RESET 8'h00
`define TTC_COUNT_MAX 16'hFFFF
`endif

// ---- logic/ttc_counter.sv ----
// Sixteen bit counter with reload, direct load and overflow pulse
`timescale 1ns/1ps
`default_nettype none
`include "ttc_consts.svh"
module ttc_counter
	import ttc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic reload_i,
	input wire logic load_i,
	input wire logic [15:0] load_val_i,
	input wire logic [15:0] reload_val_i,
	output logic [15:0] count_o,
	output logic ovf_o
);
	typedef struct packed {
		logic [15:0] count;
		logic ovf;
	} ttc_cnt_st_t;
	ttc_cnt_st_t st, next_st;
	always_comb begin
		next_st = st;
		next_st.ovf = 1'b0;
		if (tick_i) begin
			if (st.count == `TTC_COUNT_MAX) begin
				next_st.ovf = 1'b1;
				next_st.count = reload_val_i;
			end else begin
				next_st.count = st.count + 16'h0001;
			end
		end
		if (reload_i) begin
			next_st.count = reload_val_i;
		end
		if (load_i) begin
			next_st.count = load_val_i;
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign count_o = st.count;
	assign ovf_o = st.ovf;
endmodule : ttc_counter
`default_nettype wire

// ---- logic/ttc_edge.sv ----
// Pin synchroniser with falling edge detector
`timescale 1ns/1ps
`default_nettype none
module ttc_edge
	import ttc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic pin_i,
	output logic fall_o
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic fall;
	} ttc_edge_st_t;
	ttc_edge_st_t st, next_st;
	always_comb begin
		next_st = st;
		next_st.s1 = pin_i;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		next_st.fall = st.s3 & ~st.s2;
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, fall: 1'b0};
		end else begin
			st <= next_st;
		end
	end
	assign fall_o = st.fall;
endmodule : ttc_edge
`default_nettype wire

// ---- logic/ttc_pkg.sv ----
// Types shared by the second timer control logic
package ttc_pkg;
	typedef enum logic [1:0] {TTC_IDLE, TTC_RUN} ttc_state_t;
endpackage : ttc_pkg

// ---- logic/ttc_top.sv ----
// Control, status and baud selection of the second general-purpose timer
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ttc_consts.svh"
// Functional notes
// - Overflow flag set on overflow only when both serial clock selects are zero.
// - Enabled trigger falling edge causing capture or reload sets external event flag.
// - External flag raises interrupt unless up/down counting is enabled; only TIMER_IRQ_O is muted, IRQ_O still fires on the event.
// - Receive and transmit selects pick this or other timer overflow as baud.
// - Enabled trigger edge captures or reloads when not baud clock; else ignored.
// - Run control starts and stops counting.
// - Select bit picks internal clock or external count pin falling edges.
// - Capture/reload select chooses mode; serial clock selects force auto-reload.
module ttc_top
	import ttc_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,

	input wire logic COUNT_INPUT_PIN_I,
	input wire logic EXTERNAL_TRIGGER_PIN_I,

	input wire logic OTHER_TIMER_OVF_I,

	output logic RX_BAUD_TICK_O,
	output logic TX_BAUD_TICK_O,
	output logic TIMER_IRQ_O,
	output logic IRQ_O
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic up_down_count_enable;
		logic [15:0] rcap;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic [7:0] rdata;
		logic rx_tick;
		logic tx_tick;
		logic timer_irq;
		logic irq;
		ttc_state_t state;
	} ttc_st_t;

	ttc_st_t st, next_st;
	logic [1:0] rst_sync;
	logic rst_n;
	logic count_fall;
	logic trig_fall;
	logic [15:0] count;
	logic ovf;
	logic tick;
	logic baud_mode;
	logic trig_act;
	logic do_capture;
	logic do_reload;
	logic cnt_load;
	logic [15:0] cnt_load_val;

	logic wr_ctrl;
	logic wr_mode;
	logic wr_rlo;
	logic wr_rhi;
	logic wr_clo;
	logic wr_chi;
	logic wr_stat;
	logic wr_mask;

	logic ovf_event;
	logic ext_event;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// Sticky status bit: a hardware set wins over a write-one clear
	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		sticky = set | (cur & ~clr);
	endfunction : sticky

	// Baud tick source: own overflow when selected, else the other timer
	function automatic logic baud_pick(input logic sel, input logic own, input logic other);
		baud_pick = sel ? own : other;
	endfunction : baud_pick

	// External flag is silent while up/down counting is enabled
	function automatic logic timer_irq_level(input logic [7:0] c, input logic up_down);
		timer_irq_level = c[`TTC_BIT_OVF] | (c[`TTC_BIT_EXF] & ~up_down);
	endfunction : timer_irq_level

	// One level line for all unmasked sticky events
	function automatic logic irq_level(input logic [1:0] stat, input logic [1:0] msk);
		irq_level = |(stat & msk);
	endfunction : irq_level

	// Control byte: software writes, hardware flag sets on top
	function automatic logic [7:0] control_next(
		input logic [7:0] cur,
		input logic wr,
		input logic [7:0] data,
		input logic ovf_set,
		input logic ext_set
	);
		logic [7:0] v;
		v = wr ? data : cur;
		if (ovf_set) begin
			v[`TTC_BIT_OVF] = 1'b1;
		end
		if (ext_set) begin
			v[`TTC_BIT_EXF] = 1'b1;
		end
		control_next = v;
	endfunction : control_next

	// Reload pair: byte writes, whole-word capture on top
	function automatic logic [15:0] reload_next(
		input logic [15:0] cur,
		input logic wr_lo,
		input logic wr_hi,
		input logic [7:0] data,
		input logic cap,
		input logic [15:0] c
	);
		logic [15:0] v;
		v = cur;
		if (wr_lo) begin
			v[7:0] = data;
		end
		if (wr_hi) begin
			v[15:8] = data;
		end
		if (cap) begin
			v = c;
		end
		reload_next = v;
	endfunction : reload_next

	function automatic logic [7:0] read_mux(
		input logic [7:0] a,
		input ttc_st_t s,
		input logic [15:0] c
	);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`TTC_ADDR_CONTROL: begin
				v = s.ctrl;
			end
			`TTC_ADDR_MODE: begin
				v = {7'h00, s.up_down_count_enable};
			end
			`TTC_ADDR_RELOAD_LO: begin
				v = s.rcap[7:0];
			end
			`TTC_ADDR_RELOAD_HI: begin
				v = s.rcap[15:8];
			end
			`TTC_ADDR_COUNT_LO: begin
				v = c[7:0];
			end
			`TTC_ADDR_COUNT_HI: begin
				v = c[15:8];
			end
			`TTC_ADDR_IRQ_STATUS: begin
				v = {6'h00, s.irq_stat};
			end
			`TTC_ADDR_IRQ_MASK: begin
				v = {6'h00, s.irq_mask};
			end
			default: begin
				v = 8'h00;
			end
		endcase
		read_mux = v;
	endfunction : read_mux

	// Reset release through two flops
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync[0] <= 1'b1;
			rst_sync[1] <= rst_sync[0];
		end
	end
	assign rst_n = rst_sync[1];

	// Edge detectors on both external pins
	ttc_edge u_count_edge (
		.clk_i(CORE_CLK_I),
		.rst_n_i(rst_n),
		.pin_i(COUNT_INPUT_PIN_I),
		.fall_o(count_fall)
	);

	ttc_edge u_trig_edge (
		.clk_i(CORE_CLK_I),
		.rst_n_i(rst_n),
		.pin_i(EXTERNAL_TRIGGER_PIN_I),
		.fall_o(trig_fall)
	);

	always_comb begin
		baud_mode = st.ctrl[`TTC_BIT_RCLK] | st.ctrl[`TTC_BIT_TX_CLOCK_SELECT];
		tick = st.ctrl[`TTC_BIT_RUN] &
			(st.ctrl[`TTC_BIT_CT] ? count_fall : 1'b1);
		trig_act = st.ctrl[`TTC_BIT_EXEN] & trig_fall & ~baud_mode;
		do_capture = trig_act & st.ctrl[`TTC_BIT_CPRL];
		do_reload = trig_act & ~st.ctrl[`TTC_BIT_CPRL];
		cnt_load = wr_clo | wr_chi;
		cnt_load_val = count;
		if (wr_clo) begin
			cnt_load_val = {count[15:8], WDATA_I};
		end
		if (wr_chi) begin
			cnt_load_val = {WDATA_I, count[7:0]};
		end
	end

	// Flag events: overflow only outside baud use, trigger only when acted on
	always_comb begin
		ovf_event = ovf & ~baud_mode;
		ext_event = trig_act;
	end

	// Register write decode
	always_comb begin
		wr_ctrl = WR_I & hit(ADDR_I, `TTC_ADDR_CONTROL);
		wr_mode = WR_I & hit(ADDR_I, `TTC_ADDR_MODE);
		wr_rlo = WR_I & hit(ADDR_I, `TTC_ADDR_RELOAD_LO);
		wr_rhi = WR_I & hit(ADDR_I, `TTC_ADDR_RELOAD_HI);
		wr_clo = WR_I & hit(ADDR_I, `TTC_ADDR_COUNT_LO);
		wr_chi = WR_I & hit(ADDR_I, `TTC_ADDR_COUNT_HI);
		wr_stat = WR_I & hit(ADDR_I, `TTC_ADDR_IRQ_STATUS);
		wr_mask = WR_I & hit(ADDR_I, `TTC_ADDR_IRQ_MASK);
	end

	// Sixteen bit count with reload from the register pair
	ttc_counter u_counter (
		.clk_i(CORE_CLK_I),
		.rst_n_i(rst_n),
		.tick_i(tick),
		.reload_i(do_reload),
		.load_i(cnt_load),
		.load_val_i(cnt_load_val),
		.reload_val_i(st.rcap),
		.count_o(count),
		.ovf_o(ovf)
	);

	always_comb begin
		next_st = st;
		next_st.state = st.ctrl[`TTC_BIT_RUN] ? TTC_RUN : TTC_IDLE;
		next_st.ctrl = control_next(st.ctrl, wr_ctrl, WDATA_I, ovf_event, ext_event);
		if (wr_mode) begin
			next_st.up_down_count_enable = WDATA_I[`TTC_BIT_UP_DOWN_COUNT_ENABLE];
		end
		next_st.rcap = reload_next(st.rcap, wr_rlo, wr_rhi, WDATA_I, do_capture, count);
		if (wr_mask) begin
			next_st.irq_mask = WDATA_I[1:0];
		end

		next_st.irq_stat[0] = sticky(st.irq_stat[0], ovf_event, wr_stat & WDATA_I[0]);
		next_st.irq_stat[1] = sticky(st.irq_stat[1], ext_event, wr_stat & WDATA_I[1]);
		next_st.rdata = RD_I ? read_mux(ADDR_I, st, count) : 8'h00;

		next_st.rx_tick = baud_pick(st.ctrl[`TTC_BIT_RCLK], ovf, OTHER_TIMER_OVF_I);
		next_st.tx_tick = baud_pick(st.ctrl[`TTC_BIT_TX_CLOCK_SELECT], ovf, OTHER_TIMER_OVF_I);
		next_st.timer_irq = timer_irq_level(next_st.ctrl, next_st.up_down_count_enable);
		next_st.irq = irq_level(next_st.irq_stat, next_st.irq_mask);
	end

	always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{
				ctrl: `TTC_CONTROL_RESET,
				up_down_count_enable: 1'b0,
				rcap: 16'h0000,
				irq_stat: 2'h0,
				irq_mask: 2'h0,
				rdata: 8'h00,
				rx_tick: 1'b0,
				tx_tick: 1'b0,
				timer_irq: 1'b0,
				irq: 1'b0,
				state: TTC_IDLE
			};
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flops
	assign RDATA_O = st.rdata;
	assign RX_BAUD_TICK_O = st.rx_tick;
	assign TX_BAUD_TICK_O = st.tx_tick;
	assign TIMER_IRQ_O = st.timer_irq;
	assign IRQ_O = st.irq;
endmodule : ttc_top
`default_nettype wire

// ---- sim/timer_two_control_bench.sv ----
// Self-checking bench for the timer two control block
`timescale 1ns/1ps
`default_nettype none
module timer_two_control_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [7:0] a = 8'h00;
	logic [7:0] d = 8'h00;
	logic [7:0] rdata, rl, rv;
	logic cnt, trg, ovf, rx, tx, tirq, irq;
	int failures = 0;
	int compares = 0;
	int txn = 0;
	int n;
	always #5 clk = ~clk;
	always @(posedge clk) if (tx === 1'b1) txn <= txn + 1;
	ttc_far_side i_far (.clk_i(clk), .cnt_o(cnt), .trg_o(trg), .ovf_o(ovf));
	ttc_top i_dut (.CORE_CLK_I(clk), .RESETN_I(rst_n), .ADDR_I(a), .WDATA_I(d), .WR_I(we),
		.RD_I(re), .RDATA_O(rdata), .COUNT_INPUT_PIN_I(cnt), .EXTERNAL_TRIGGER_PIN_I(trg),
		.OTHER_TIMER_OVF_I(ovf), .RX_BAUD_TICK_O(rx), .TX_BAUD_TICK_O(tx),
		.TIMER_IRQ_O(tirq), .IRQ_O(irq));
	task automatic report_and_stop;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	task automatic ck(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : ck
	task automatic w(input logic [7:0] ad, input logic [7:0] dt);
		@(posedge clk);
		a <= ad;
		d <= dt;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask : w
	task automatic r(input logic [7:0] ad, input logic [7:0] exp);
		@(posedge clk);
		a <= ad;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 ck(rdata, exp);
	endtask : r
	task automatic wt(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : wt
	initial begin
		void'($urandom(32'hC52E));
		rl = 8'h10 | (8'($urandom) & 8'h6F);
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		wt(3);
		r(8'hC8, 8'h00);
		r(8'hE1, 8'h00);
		r(8'h00, 8'h00);
		for (int i = 0; i < 4; i++) begin
			rv = 8'($urandom) & 8'h3F;
			w(8'hC8, rv);
			r(8'hC8, rv);
		end
		$display("end regs");
		w(8'hC8, 8'h00);
		w(8'hE1, 8'h01);
		w(8'hCC, 8'hF0);
		w(8'hCD, 8'hFF);
		w(8'hCB, rl);
		w(8'hC8, 8'h04);
		wt(24);
		ck({7'h00, tirq}, 8'h01);
		ck({7'h00, irq}, 8'h01);
		r(8'hC8, 8'h84);
		r(8'hCD, rl);
		r(8'hE0, 8'h01);
		w(8'hE0, 8'h01);
		w(8'hC8, 8'h00);
		wt(3);
		ck({6'h00, tirq, irq}, 8'h00);
		w(8'hCC, 8'h00);
		w(8'hCD, 8'h00);
		w(8'hC8, 8'h06);
		repeat (5) i_far.fall(1'b0);
		r(8'hCC, 8'h05);
		w(8'hC8, 8'h0C);
		i_far.fall(1'b1);
		r(8'hC8, 8'h4C);
		r(8'hCD, rl);
		w(8'hC9, 8'h01);
		wt(3);
		ck({7'h00, tirq}, 8'h00);
		$display("end flags");
		w(8'hC8, 8'h00);
		w(8'hCD, 8'h5A);
		w(8'hC8, 8'h0D);
		i_far.fall(1'b1);
		r(8'hCB, 8'h5A);
		w(8'hC8, 8'h00);
		i_far.fall(1'b1);
		r(8'hC8, 8'h00);
		w(8'hCC, 8'hF0);
		w(8'hCD, 8'hFF);
		n = txn;
		w(8'hC8, 8'h34);
		wt(24);
		ck(8'(txn - n), 8'h01);
		r(8'hC8, 8'h34);
		w(8'hC8, 8'h00);
		n = txn;
		i_far.pulse();
		wt(3);
		ck(8'(txn - n), 8'h01);
		$display("end baud");
		report_and_stop();
	end
	initial begin
		#50000;
		failures++;
		report_and_stop();
	end
endmodule : timer_two_control_bench
`default_nettype wire

// ---- sim/ttc_far_side.sv ----
// Far side model: external pins and other timer overflow
`timescale 1ns/1ps
`default_nettype none
module ttc_far_side (
	input wire logic clk_i,
	output logic cnt_o = 1'b1,
	output logic trg_o = 1'b1,
	output logic ovf_o = 1'b0
);
	task automatic fall(input logic trig);
		@(posedge clk_i);
		if (trig) trg_o <= 1'b0;
		else cnt_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		trg_o <= 1'b1;
		cnt_o <= 1'b1;
		repeat (2) @(posedge clk_i);
	endtask : fall
	task automatic pulse;
		@(posedge clk_i);
		ovf_o <= 1'b1;
		@(posedge clk_i);
		ovf_o <= 1'b0;
	endtask : pulse
endmodule : ttc_far_side
`default_nettype wire

// ---- sim/ttc_top_assertions.sv ----
// Port checker for the timer two control block
`timescale 1ns/1ps
`default_nettype none
module ttc_chk (
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [7:0] RDATA_O,
	input wire logic OTHER_TIMER_OVF_I,
	input wire logic RX_BAUD_TICK_O,
	input wire logic TX_BAUD_TICK_O,
	input wire logic TIMER_IRQ_O,
	input wire logic IRQ_O
);
	logic [5:0] ctl;
	logic [7:0] msk;
	logic q;
	// Baud mode, trigger off, no write
	assign q = (ctl[5] | ctl[4]) & ~ctl[3] & ~WR_I;
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ctl <= 6'h00;
			msk <= 8'h00;
		end else if (WR_I && ADDR_I == 8'hC8) begin
			ctl <= WDATA_I[5:0];
		end else if (WR_I && ADDR_I == 8'hE1) begin
			msk <= WDATA_I;
		end
	end
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);
	a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("rdata idle");
	a_rdata_unmapped: assert property ($past(RD_I && ADDR_I == 8'h00) |-> RDATA_O == 8'h00)
		else $error("unmapped read");
	a_ctl_readback: assert property ($past(RD_I && ADDR_I == 8'hC8) |-> RDATA_O[5:0] == $past(ctl))
		else $error("control read");
	a_tx_other: assert property (!$past(ctl[4]) |-> TX_BAUD_TICK_O == $past(OTHER_TIMER_OVF_I))
		else $error("tx baud");
	a_rx_other: assert property (!$past(ctl[5]) |-> RX_BAUD_TICK_O == $past(OTHER_TIMER_OVF_I))
		else $error("rx baud");
	a_baud_same: assert property ($past(ctl[5] == ctl[4]) |-> RX_BAUD_TICK_O == TX_BAUD_TICK_O)
		else $error("baud pair");
	a_flags_quiet: assert property ($past(q) && $past(q, 2) |-> !$rose(TIMER_IRQ_O))
		else $error("flag in baud");
	a_irq_masked: assert property ($past(msk) == 8'h00 |-> !IRQ_O)
		else $error("masked irq");
endmodule : ttc_chk
bind ttc_top ttc_chk i_chk (.CORE_CLK_I, .RESETN_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
	.OTHER_TIMER_OVF_I, .RX_BAUD_TICK_O, .TX_BAUD_TICK_O, .TIMER_IRQ_O, .IRQ_O);
`default_nettype wire
